// *** design/agtc_coeff_if.sv ***
// Carries trim loads into the coefficient store and the held values back out
interface agtc_coeff_if;
  logic                 load;
  logic                 lock;
  agtc_pkg::agtc_order0_t trim0;
  agtc_pkg::agtc_order1_t trim1;
  agtc_pkg::agtc_order2_t trim2;
  agtc_pkg::agtc_order0_t coef0;
  agtc_pkg::agtc_order1_t coef1;
  agtc_pkg::agtc_order2_t coef2;
  logic                 loaded;

  modport ctrl  (output load, lock, trim0, trim1, trim2, input coef0, coef1, coef2, loaded);
  modport store (input load, lock, trim0, trim1, trim2, output coef0, coef1, coef2, loaded);
endinterface

// *** design/agtc_coeff_store.sv ***
`include "agtc_map.svh"

// Holds the three factory coefficients; only the trim path can change them
module agtc_coeff_store (
  input  wire logic  pclk,
  input  wire logic  presetn,
  agtc_coeff_if.store cif
);

  logic take;

  // A load counts only while software has not locked the values
  assign take = cif.load & ~cif.lock;

  // Coefficient flops, zero after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.coef0 <= '0;
      cif.coef1 <= '0;
      cif.coef2 <= '0;
    end else if (take) begin
      cif.coef0 <= cif.trim0;
      cif.coef1 <= cif.trim1;
      cif.coef2 <= cif.trim2;
    end
  end

  // Sticky flag: at least one load was accepted since reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.loaded <= `AGTC_COEFF_RST;
    end else if (take) begin
      cif.loaded <= 1'b1;
    end
  end

endmodule // agtc_coeff_store

// *** design/agtc_map.svh ***
// Overview of operation
// - Order-0 bits 7:0 fill byte 0x51
// - Order-0 bits 14:8 on 0x52 bits 6:0
// - Order-1 bit 0 on 0x52 bit 7
// - Order-1 bits 8:1 fill byte 0x53
// - Order-1 bits 13:9 on 0x54 bits 4:0
// - Order-2 bits 2:0 on 0x54 bits 7:5
// - Order-2 bits 10:3 fill byte 0x55
// - Order-2 bits 13:11 in next byte 0x56
`ifndef AGTC_MAP_SVH
`define AGTC_MAP_SVH

// Register indexes; byte address is four times the index
`define AGTC_IDX_O0_LOW       10'h051
`define AGTC_IDX_O0HI_O1LSB   10'h052
`define AGTC_IDX_O1_MID       10'h053
`define AGTC_IDX_O1HI_O2LOW   10'h054
`define AGTC_IDX_O2_MID       10'h055
`define AGTC_IDX_O2_HIGH      10'h056
`define AGTC_IDX_LOCK         10'h060
`define AGTC_IDX_STATUS       10'h061

// APB address slice that carries the word index
`define AGTC_PADDR_W          12
`define AGTC_IDX_RANGE        11:2

// Decoded words in the read table
`define AGTC_NSLOT            8

// Coefficient slices packed into the bytes
`define AGTC_O0_LOW           7:0
`define AGTC_O0_HIGH          14:8
`define AGTC_O1_LSB           0
`define AGTC_O1_MID           8:1
`define AGTC_O1_HIGH          13:9
`define AGTC_O2_LOW           2:0
`define AGTC_O2_MID           10:3
`define AGTC_O2_HIGH          13:11

// Control and status bit positions
`define AGTC_LOCK_BIT         0
`define AGTC_LOADED_BIT       0

// Reset values and zero pads
`define AGTC_COEFF_RST        1'b0
`define AGTC_BYTE_RST         8'h00
`define AGTC_WORD_RST         32'h0000_0000
`define AGTC_O2HI_PAD         5'h00
`define AGTC_FLAG_PAD         7'h00
`define AGTC_WORD_PAD         24'h00_0000

`endif

// *** design/agtc_pkg.sv ***
package agtc_pkg;
  typedef logic [14:0] agtc_order0_t;
  typedef logic [13:0] agtc_order1_t;
  typedef logic [13:0] agtc_order2_t;
  typedef logic [7:0]  agtc_byte_t;
endpackage

// *** design/agtc_regs.sv ***
`include "agtc_map.svh"

// Read-only bank of gain temperature-correction coefficient bytes on APB.
// The three coefficients are packed across consecutive bytes; software
// reads the bytes and reassembles them. Each byte sits in the low eight
// bits of an aligned word, upper bits read zero.
//
// Word map, by index (byte address is four times the index):
//   0x51  order-0 bits 7:0
//   0x52  order-1 bit 0 over order-0 bits 14:8
//   0x53  order-1 bits 8:1
//   0x54  order-2 bits 2:0 over order-1 bits 13:9
//   0x55  order-2 bits 10:3
//   0x56  order-2 bits 13:11, upper five bits zero
//   0x60  lock, bit 0; a set lock blocks trim loads
//   0x61  loaded, bit 0; set by the first accepted trim load
//
// Timing: one wait state, so ready comes the cycle after the access
// phase starts. Writes to coefficient and status words are dropped
// without an error; unmapped words answer with an error and read zero.
// Trim loads come from fuse logic on pclk; an accepted load shows on
// the coefficient outputs and words one cycle later.
module agtc_regs (
  // Clock, reset and APB slave side
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`AGTC_PADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,

  // Factory trim path, same clock as the bus
  input  wire logic                     trim_load,
  input  wire agtc_pkg::agtc_order0_t   trim_order0,
  input  wire agtc_pkg::agtc_order1_t   trim_order1,
  input  wire agtc_pkg::agtc_order2_t   trim_order2,

  // Held coefficients
  output agtc_pkg::agtc_order0_t        gain_tempco_order0,
  output agtc_pkg::agtc_order1_t        gain_tempco_order1,
  output agtc_pkg::agtc_order2_t        gain_tempco_order2
);

  // Bus response flops
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;

  // Software lock of the trim path
  logic        lock_r;
  logic        lock_nxt;

  // Carrier to the coefficient store
  agtc_coeff_if cif ();

  // Trim inputs come from fuse logic on pclk, so they need no synchroniser
  assign cif.load  = trim_load;
  assign cif.lock  = lock_r;
  assign cif.trim0 = trim_order0;
  assign cif.trim1 = trim_order1;
  assign cif.trim2 = trim_order2;

  agtc_coeff_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif)
  );

  // Coefficients leave straight from the store flops
  assign gain_tempco_order0 = cif.coef0;
  assign gain_tempco_order1 = cif.coef1;
  assign gain_tempco_order2 = cif.coef2;

  // Access phase seen for the first time; one wait state follows setup
  logic                     access;
  logic [9:0]               idx;
  logic                     wr_acc;
  logic                     rd_acc;

  assign access = psel & penable & ~pready_r;
  assign idx    = paddr[`AGTC_IDX_RANGE];
  assign wr_acc = access & pwrite;
  assign rd_acc = access & ~pwrite;

  // Address decode
  logic hit_o0_low;
  logic hit_o0hi_o1lsb;
  logic hit_o1_mid;
  logic hit_o1hi_o2low;
  logic hit_o2_mid;
  logic hit_o2_high;
  logic hit_lock;
  logic hit_status;
  logic hit_coeff;
  logic hit_any;

  // Coefficient words
  assign hit_o0_low     = (idx == `AGTC_IDX_O0_LOW);
  assign hit_o0hi_o1lsb = (idx == `AGTC_IDX_O0HI_O1LSB);
  assign hit_o1_mid     = (idx == `AGTC_IDX_O1_MID);
  assign hit_o1hi_o2low = (idx == `AGTC_IDX_O1HI_O2LOW);
  assign hit_o2_mid     = (idx == `AGTC_IDX_O2_MID);
  assign hit_o2_high    = (idx == `AGTC_IDX_O2_HIGH);

  // Own control and status words
  assign hit_lock       = (idx == `AGTC_IDX_LOCK);
  assign hit_status     = (idx == `AGTC_IDX_STATUS);
  assign hit_coeff      = hit_o0_low | hit_o0hi_o1lsb | hit_o1_mid
                        | hit_o1hi_o2low | hit_o2_mid | hit_o2_high;
  assign hit_any        = hit_coeff | hit_lock | hit_status;

  // Byte images of the packed coefficients
  agtc_pkg::agtc_byte_t byte_o0_low;
  agtc_pkg::agtc_byte_t byte_o0hi_o1lsb;
  agtc_pkg::agtc_byte_t byte_o1_mid;
  agtc_pkg::agtc_byte_t byte_o1hi_o2low;
  agtc_pkg::agtc_byte_t byte_o2_mid;
  agtc_pkg::agtc_byte_t byte_o2_high;
  agtc_pkg::agtc_byte_t byte_lock;
  agtc_pkg::agtc_byte_t byte_status;

  // Order-0 low byte
  assign byte_o0_low     = cif.coef0[`AGTC_O0_LOW];

  // Order-1 bit 0 above the order-0 upper bits
  assign byte_o0hi_o1lsb = {cif.coef1[`AGTC_O1_LSB],
                            cif.coef0[`AGTC_O0_HIGH]};

  // Order-1 middle bits
  assign byte_o1_mid     = cif.coef1[`AGTC_O1_MID];

  // Order-2 low bits above the order-1 upper bits
  assign byte_o1hi_o2low = {cif.coef2[`AGTC_O2_LOW],
                            cif.coef1[`AGTC_O1_HIGH]};

  // Order-2 middle bits
  assign byte_o2_mid     = cif.coef2[`AGTC_O2_MID];

  // Order-2 upper bits; the rest of the byte reads zero
  assign byte_o2_high    = {`AGTC_O2HI_PAD, cif.coef2[`AGTC_O2_HIGH]};

  // Lock and loaded flags in bit 0
  assign byte_lock       = {`AGTC_FLAG_PAD, lock_r};
  assign byte_status     = {`AGTC_FLAG_PAD, cif.loaded};

  // Read data selection: a table in index order, one slot per decoded word
  agtc_pkg::agtc_byte_t                     rd_byte;
  logic [`AGTC_NSLOT-1:0]                   slot_hit;
  agtc_pkg::agtc_byte_t [`AGTC_NSLOT-1:0]   slot_byte;

  assign slot_hit  = {hit_status, hit_lock, hit_o2_high, hit_o2_mid,
                      hit_o1hi_o2low, hit_o1_mid, hit_o0hi_o1lsb, hit_o0_low};
  assign slot_byte = {byte_status, byte_lock, byte_o2_high, byte_o2_mid,
                      byte_o1hi_o2low, byte_o1_mid, byte_o0hi_o1lsb, byte_o0_low};

  // Per bit, OR of the hit slots; hits are exclusive, unmapped words read zero
  for (genvar b = 0; b < $bits(agtc_pkg::agtc_byte_t); b++) begin : g_bit
    logic [`AGTC_NSLOT-1:0] col;
    for (genvar s = 0; s < `AGTC_NSLOT; s++) begin : g_slot
      assign col[s] = slot_hit[s] & slot_byte[s][b];
    end
    assign rd_byte[b] = |col;
  end

  assign prdata_nxt  = rd_acc ? {`AGTC_WORD_PAD, rd_byte} : `AGTC_WORD_RST;

  // Unmapped addresses answer with an error; coefficient writes do not
  assign pslverr_nxt = access & ~hit_any;

  // Ready pulses one cycle after the access phase begins
  assign pready_nxt = access;

  // Only the lock word takes a write; coefficient words drop it
  assign lock_nxt = (wr_acc && hit_lock) ? pwdata[`AGTC_LOCK_BIT] : lock_r;

  // Ready flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
    end
  end

  // Read data flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= `AGTC_WORD_RST;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // Error flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= pslverr_nxt;
    end
  end

  // Lock flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= `AGTC_COEFF_RST;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

endmodule // agtc_regs

// *** verif/agtc_regs_assertions.sv ***
`include "agtc_map.svh"

// Watches the register bank ports for byte packing and handshake timing
module agtc_regs_assertions (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [`AGTC_PADDR_W-1:0] paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     trim_load,
  input wire agtc_pkg::agtc_order0_t   trim_order0,
  input wire agtc_pkg::agtc_order1_t   trim_order1,
  input wire agtc_pkg::agtc_order2_t   trim_order2,
  input wire agtc_pkg::agtc_order0_t   gain_tempco_order0,
  input wire agtc_pkg::agtc_order1_t   gain_tempco_order1,
  input wire agtc_pkg::agtc_order2_t   gain_tempco_order2
);
  // Short names for the decode of a completed read or write
  wire [9:0]  idx = paddr[`AGTC_IDX_RANGE];
  wire        rd  = psel && penable && pready && !pwrite && !pslverr;
  wire        wr  = psel && penable && pready && pwrite;
  wire [14:0] g0  = gain_tempco_order0;
  wire [13:0] g1  = gain_tempco_order1;
  wire [13:0] g2  = gain_tempco_order2;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_byte_51: assert property (rd && idx == 10'h051 && $stable(g0)
    |-> prdata == {24'h00_0000, g0[7:0]}) else $error("byte 51 wrong");
  chk_byte_52: assert property (rd && idx == 10'h052 && $stable(g0)
    && $stable(g1) |-> prdata == {24'h00_0000, g1[0], g0[14:8]})
    else $error("byte 52 wrong");
  chk_byte_53: assert property (rd && idx == 10'h053 && $stable(g1)
    |-> prdata == {24'h00_0000, g1[8:1]}) else $error("byte 53 wrong");
  chk_byte_54: assert property (rd && idx == 10'h054 && $stable(g1)
    && $stable(g2) |-> prdata == {24'h00_0000, g2[2:0], g1[13:9]})
    else $error("byte 54 wrong");
  chk_byte_55: assert property (rd && idx == 10'h055 && $stable(g2)
    |-> prdata == {24'h00_0000, g2[10:3]}) else $error("byte 55 wrong");
  chk_byte_56: assert property (rd && idx == 10'h056 && $stable(g2)
    |-> prdata == {29'h0, g2[13:11]}) else $error("byte 56 wrong");
  chk_write_ignored: assert property (wr && idx >= 10'h051 && idx <= 10'h056
    && !$past(trim_load) |-> $stable(g0) && $stable(g1) && $stable(g2) && !pslverr)
    else $error("write landed");
  chk_answer_next: assert property (psel && penable && !pready |=> pready [*1] ##1 !pready)
    else $error("answer timing wrong");
endmodule // agtc_regs_assertions

bind agtc_regs agtc_regs_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .trim_load(trim_load), .trim_order0(trim_order0), .trim_order1(trim_order1),
  .trim_order2(trim_order2), .gain_tempco_order0(gain_tempco_order0),
  .gain_tempco_order1(gain_tempco_order1), .gain_tempco_order2(gain_tempco_order2)
);

// *** verif/agtc_regs_bench.sv ***
module agtc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                   pwrite = 1'b0, trim_load = 1'b0, pready, pslverr, err;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0000_0000, prdata, rdat, tmp, seed = 32'h0000_001d;
  agtc_pkg::agtc_order0_t t0 = 15'h0000, c0 = 15'h0000, g0;
  agtc_pkg::agtc_order1_t t1 = 14'h0000, c1 = 14'h0000, g1;
  agtc_pkg::agtc_order2_t t2 = 14'h0000, c2 = 14'h0000, g2;
  int                     failures = 0, n_tests = 0;

  agtc_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trim_load(trim_load), .trim_order0(t0), .trim_order1(t1),
    .trim_order2(t2), .gain_tempco_order0(g0), .gain_tempco_order1(g1),
    .gain_tempco_order2(g2));

  // 4 ns clock
  always #2 pclk = ~pclk;

  // Xorshift source, fixed start
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected word for each coefficient byte
  function automatic logic [31:0] exb(input logic [9:0] i);
    case (i)
      10'h051: exb = {24'h00_0000, c0[7:0]};
      10'h052: exb = {24'h00_0000, c1[0], c0[14:8]};
      10'h053: exb = {24'h00_0000, c1[8:1]};
      10'h054: exb = {24'h00_0000, c2[2:0], c1[13:9]};
      10'h055: exb = {24'h00_0000, c2[10:3]};
      default: exb = {29'h0, c2[13:11]};
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic trim(input logic [14:0] a, input logic [13:0] b, input logic [13:0] c);
    @(posedge pclk);
    trim_load <= 1'b1;
    t0 <= a;
    t1 <= b;
    t2 <= c;
    @(posedge pclk);
    trim_load <= 1'b0;
  endtask

  // Held coefficient outputs against the model, one edge after a load settles
  task automatic chkout();
    @(posedge pclk);
    chk(32'(g0), 32'(c0));
    chk(32'(g1), 32'(c1));
    chk(32'(g2), 32'(c2));
  endtask

  task automatic rdall();
    for (int i = 'h51; i <= 'h56; i++) begin
      apb(1'b0, i[9:0], 32'h0000_0000);
      chk(rdat, exb(i[9:0]));
    end
  endtask

  task automatic end_of_test();
    $display("failures=%0d comparisons=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence: reset values, random loads, ignored writes, lock, errors
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdall();
    for (int n = 0; n < 20; n++) begin
      tmp = xs();
      c0 = (n == 0) ? 15'h7fff : tmp[14:0];
      c1 = (n == 0) ? 14'h3fff : tmp[28:15];
      tmp = xs();
      c2 = (n == 0) ? 14'h3fff : tmp[13:0];
      trim(c0, c1, c2);
      chkout();
      apb(1'b1, 10'h051 + 10'(tmp[31:16] % 6), xs());
      chk({31'h0, err}, 32'h0000_0000);
      rdall();
    end
    apb(1'b1, 10'h060, 32'h0000_0001);
    apb(1'b0, 10'h060, 32'h0000_0000);
    chk(rdat, 32'h0000_0001);
    trim(~c0, ~c1, ~c2);
    chkout();
    rdall();
    apb(1'b1, 10'h060, 32'h0000_0000);
    apb(1'b1, 10'h061, 32'h0000_0000);
    apb(1'b0, 10'h061, 32'h0000_0000);
    chk(rdat, 32'h0000_0001);
    apb(1'b0, 10'h3ff, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    // Mid-run reset: words, flags and outputs all return to zero
    @(posedge pclk);
    presetn <= 1'b0;
    c0 = 15'h0000;
    c1 = 14'h0000;
    c2 = 14'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chkout();
    rdall();
    apb(1'b0, 10'h060, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    apb(1'b0, 10'h061, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    end_of_test();
  end

  // Hang guard
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule // agtc_regs_bench
